// ===== rtl/psa_packed_sat_adder.sv
// Purpose: Single-cycle packed saturating add unit, write-back after the E1 edge
// Assumes: Decode supplies the opfield, predicate result and operands in one cycle
// Notes: All outputs registered; the saturation flag port stays quiet
`timescale 1ns/1ns
module psa_packed_sat_adder
	import psa_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst_b,
	input wire logic clkEn,
	input wire logic issue,
	input wire logic [PSA_OPF_W-1:0] opfield,
	input wire logic predTrue,
	input wire logic [PSA_DATA_W-1:0] src1,
	input wire logic [PSA_DATA_W-1:0] src2,
	input wire logic [PSA_REG_W-1:0] dstAddr,
	output logic wrEn,
	output logic [PSA_REG_W-1:0] wrAddr,
	output logic [PSA_DATA_W-1:0] wrData,
	output logic satFlagWr
);
	psa_lane_if laneIf [2] ();
	psa_mode_type mode;
	logic [PSA_DATA_W-1:0] laneResult;
	logic next_wrEn;
	logic [PSA_REG_W-1:0] next_wrAddr;
	logic [PSA_DATA_W-1:0] next_wrData;
	logic next_satFlagWr;

	always_comb begin
		case (opfield)
			PSA_OPF_SIGNED_PAIR: mode = PSA_MODE_SIGNED_PAIR;
			PSA_OPF_UNSIGNED_SIGNED_PAIR: mode = PSA_MODE_UNSIGNED_SIGNED_PAIR;
			PSA_OPF_UNSIGNED_QUAD: mode = PSA_MODE_UNSIGNED_QUAD;
			default: mode = PSA_MODE_NONE;
		endcase
	end

	// Lane h takes bits of half h of both sources and returns to the same half
	for (genvar h = 0; h < 2; h++) begin : g_lane
		assign laneIf[h].mode = mode;
		assign laneIf[h].opA = src1[PSA_HALF_W*h +: PSA_HALF_W];
		assign laneIf[h].opB = src2[PSA_HALF_W*h +: PSA_HALF_W];
		assign laneResult[PSA_HALF_W*h +: PSA_HALF_W] = laneIf[h].sum;
		psa_lane u_lane (
			.lane(laneIf[h])
		);
	end

	always_comb begin
		// Unknown opfields and false predicates issue no write at all
		next_wrEn = issue && predTrue && (mode != PSA_MODE_NONE);
		next_wrAddr = dstAddr;
		next_wrData = laneResult;
		// The unit never reports saturation, even when a lane clamps
		next_satFlagWr = 1'b0;
		if (!next_wrEn) begin
			next_wrAddr = wrAddr;
			next_wrData = wrData;
		end
	end

	// Reset also waits for an enabled edge, so a low enable freezes every bit without exception
	always_ff @(posedge ref_clk) begin
		if (clkEn) begin
			if (!rst_b) begin
				wrEn <= 1'b0;
				wrAddr <= PSA_ADDR_RST;
				wrData <= PSA_DATA_RST;
				satFlagWr <= 1'b0;
			end else begin
				wrEn <= next_wrEn;
				wrAddr <= next_wrAddr;
				wrData <= next_wrData;
				satFlagWr <= next_satFlagWr;
			end
		end
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_b);

	sequence issueOp(logic [3:0] code);
		clkEn && issue && predTrue && opfield == code;
	endsequence

	sequence writeNext;
		##1 wrEn;
	endsequence

	// A decodable, predicated, enabled issue: the only thing allowed to raise wrEn
	sequence validIssue;
		clkEn && issue && predTrue && mode != PSA_MODE_NONE;
	endsequence

	sequence noValidIssue;
		clkEn && !(issue && predTrue && mode != PSA_MODE_NONE);
	endsequence

	// Issue and write-back bookkeeping
	pred_false_nop_a: assert property (clkEn && issue && !predTrue |=> !wrEn && $stable(wrData))
		else $error("False predicate produced a write");
	zero_delay_wb_a: assert property (issueOp(PSA_OPF_UNSIGNED_QUAD) |-> writeNext ##0 wrAddr == $past(dstAddr))
		else $error("Result not written one cycle after issue");
	any_write_addr_a: assert property (validIssue |=> wrEn && wrAddr == $past(dstAddr))
		else $error("Valid issue did not write its destination next cycle");
	idle_no_write_a: assert property (noValidIssue |=> !wrEn)
		else $error("Write issued without a valid instruction");
	unknown_op_hold_a: assert property (clkEn && issue && mode == PSA_MODE_NONE
		|=> !wrEn && $stable(wrData) && $stable(wrAddr))
		else $error("Unknown opfield changed the destination");

	// Signed pair lanes; every lane is checked alone, so a carry across the middle trips the upper-lane check
	s16_high_clamp_a: assert property (issueOp(PSA_OPF_SIGNED_PAIR)
		and ($signed(src1[31:16]) + $signed(src2[31:16]) > 32767) |=> wrData[31:16] == 16'h7FFF)
		else $error("Signed upper lane did not clamp high");
	s16_upper_low_a: assert property (issueOp(PSA_OPF_SIGNED_PAIR)
		and ($signed(src1[31:16]) + $signed(src2[31:16]) < -32768) |=> wrData[31:16] == 16'h8000)
		else $error("Signed upper lane did not clamp low");
	s16_lower_high_a: assert property (issueOp(PSA_OPF_SIGNED_PAIR)
		and ($signed(src1[15:0]) + $signed(src2[15:0]) > 32767) |=> wrData[15:0] == 16'h7FFF)
		else $error("Signed lower lane did not clamp high");
	s16_low_clamp_a: assert property (issueOp(PSA_OPF_SIGNED_PAIR)
		and ($signed(src1[15:0]) + $signed(src2[15:0]) < -32768) |=> wrData[15:0] == 16'h8000)
		else $error("Signed lower lane did not clamp low");
	s16_pass_lower_a: assert property (issueOp(PSA_OPF_SIGNED_PAIR)
		and ($signed(src1[15:0]) + $signed(src2[15:0]) <= 32767)
		and ($signed(src1[15:0]) + $signed(src2[15:0]) >= -32768)
		|=> wrData[15:0] == 16'($past(src1[15:0]) + $past(src2[15:0])))
		else $error("Signed lower lane altered an in-range sum");
	s16_upper_pass_a: assert property (issueOp(PSA_OPF_SIGNED_PAIR)
		and ($signed(src1[31:16]) + $signed(src2[31:16]) <= 32767)
		and ($signed(src1[31:16]) + $signed(src2[31:16]) >= -32768)
		|=> wrData[31:16] == 16'($past(src1[31:16]) + $past(src2[31:16])))
		else $error("Signed upper lane altered an in-range sum");

	// Unsigned byte lanes
	u8_byte0_clamp_a: assert property (issueOp(PSA_OPF_UNSIGNED_QUAD)
		and ({1'b0, src1[7:0]} + {1'b0, src2[7:0]} > 9'd255) |=> wrData[7:0] == 8'hFF)
		else $error("Byte 0 did not clamp at 255");
	u8_byte1_clamp_a: assert property (issueOp(PSA_OPF_UNSIGNED_QUAD)
		and ({1'b0, src1[15:8]} + {1'b0, src2[15:8]} > 9'd255) |=> wrData[15:8] == 8'hFF)
		else $error("Byte 1 did not clamp at 255");
	u8_byte2_clamp_a: assert property (issueOp(PSA_OPF_UNSIGNED_QUAD)
		and ({1'b0, src1[23:16]} + {1'b0, src2[23:16]} > 9'd255) |=> wrData[23:16] == 8'hFF)
		else $error("Byte 2 did not clamp at 255");
	u8_byte3_clamp_a: assert property (issueOp(PSA_OPF_UNSIGNED_QUAD)
		and ({1'b0, src1[31:24]} + {1'b0, src2[31:24]} > 9'd255) |=> wrData[31:24] == 8'hFF)
		else $error("Byte 3 did not clamp at 255");
	u8_byte0_pass_a: assert property (issueOp(PSA_OPF_UNSIGNED_QUAD)
		and ({1'b0, src1[7:0]} + {1'b0, src2[7:0]} <= 9'd255)
		|=> wrData[7:0] == 8'($past(src1[7:0]) + $past(src2[7:0])))
		else $error("Byte 0 changed an in-range sum");
	u8_byte1_pass_a: assert property (issueOp(PSA_OPF_UNSIGNED_QUAD)
		and ({1'b0, src1[15:8]} + {1'b0, src2[15:8]} <= 9'd255)
		|=> wrData[15:8] == 8'($past(src1[15:8]) + $past(src2[15:8])))
		else $error("Byte 1 took a carry or changed an in-range sum");
	u8_byte2_pass_a: assert property (issueOp(PSA_OPF_UNSIGNED_QUAD)
		and ({1'b0, src1[23:16]} + {1'b0, src2[23:16]} <= 9'd255)
		|=> wrData[23:16] == 8'($past(src1[23:16]) + $past(src2[23:16])))
		else $error("Byte 2 took a carry or changed an in-range sum");
	u8_byte3_pass_a: assert property (issueOp(PSA_OPF_UNSIGNED_QUAD)
		and ({1'b0, src1[31:24]} + {1'b0, src2[31:24]} <= 9'd255)
		|=> wrData[31:24] == 8'($past(src1[31:24]) + $past(src2[31:24])))
		else $error("Byte 3 took a carry or changed an in-range sum");

	// Mixed-sign lanes: first source unsigned, second signed
	mixed_zero_clamp_a: assert property (issueOp(PSA_OPF_UNSIGNED_SIGNED_PAIR)
		and ($signed({1'b0, src1[15:0]}) + $signed(src2[15:0]) < 0) |=> wrData[15:0] == 16'h0000)
		else $error("Mixed lower lane did not clamp to zero");
	mixed_up_zero_a: assert property (issueOp(PSA_OPF_UNSIGNED_SIGNED_PAIR)
		and ($signed({1'b0, src1[31:16]}) + $signed(src2[31:16]) < 0) |=> wrData[31:16] == 16'h0000)
		else $error("Mixed upper lane did not clamp to zero");
	mixed_low_top_a: assert property (issueOp(PSA_OPF_UNSIGNED_SIGNED_PAIR)
		and ($signed({1'b0, src1[15:0]}) + $signed(src2[15:0]) > 65535) |=> wrData[15:0] == 16'hFFFF)
		else $error("Mixed lower lane did not clamp to 65535");
	mixed_top_clamp_a: assert property (issueOp(PSA_OPF_UNSIGNED_SIGNED_PAIR)
		and ($signed({1'b0, src1[31:16]}) + $signed(src2[31:16]) > 65535) |=> wrData[31:16] == 16'hFFFF)
		else $error("Mixed upper lane did not clamp to 65535");
	mixed_low_pass_a: assert property (issueOp(PSA_OPF_UNSIGNED_SIGNED_PAIR)
		and ($signed({1'b0, src1[15:0]}) + $signed(src2[15:0]) >= 0)
		and ($signed({1'b0, src1[15:0]}) + $signed(src2[15:0]) <= 65535)
		|=> wrData[15:0] == 16'($past(src1[15:0]) + $past(src2[15:0])))
		else $error("Mixed lower lane altered an in-range sum");
	mixed_up_pass_a: assert property (issueOp(PSA_OPF_UNSIGNED_SIGNED_PAIR)
		and ($signed({1'b0, src1[31:16]}) + $signed(src2[31:16]) >= 0)
		and ($signed({1'b0, src1[31:16]}) + $signed(src2[31:16]) <= 65535)
		|=> wrData[31:16] == 16'($past(src1[31:16]) + $past(src2[31:16])))
		else $error("Mixed upper lane altered an in-range sum");

	// Port-level behaviour
	sat_flag_quiet_a: assert property (!satFlagWr)
		else $error("Saturation flag was touched");
	// Checked while reset is held, so the default disable is overridden here
	rst_quiet_a: assert property (disable iff (1'b0) !rst_b && clkEn
		|=> !wrEn && wrData == PSA_DATA_RST && wrAddr == PSA_ADDR_RST && !satFlagWr)
		else $error("Reset left the write port busy");
	// A low enable must hold wrEn, wrData and wrAddr, a pending write included
	freeze_hold_a: assert property (!clkEn |=> $stable(wrEn) && $stable(wrData) && $stable(wrAddr))
		else $error("Outputs moved while the clock enable was low");
endmodule

// ===== rtl/psa_pkg.sv
// Purpose: Shared constants and types of the packed saturating adder
// Assumes: 32-bit operands, 16-bit halves, 8-bit bytes
// Notes: Opfield codes select the operation within the S-unit group
package psa_pkg;
	localparam int PSA_DATA_W = 32;
	localparam int PSA_HALF_W = 16;
	localparam int PSA_BYTE_W = 8;
	localparam int PSA_OPF_W = 4;
	localparam int PSA_REG_W = 5;
	localparam logic [3:0] PSA_OPF_SIGNED_PAIR = 4'h0;
	localparam logic [3:0] PSA_OPF_UNSIGNED_SIGNED_PAIR = 4'h1;
	localparam logic [3:0] PSA_OPF_UNSIGNED_QUAD = 4'h3;
	localparam logic [15:0] PSA_S16_MAX = 16'h7FFF;
	localparam logic [15:0] PSA_S16_MIN = 16'h8000;
	localparam logic [15:0] PSA_U16_MAX = 16'hFFFF;
	localparam logic [15:0] PSA_U16_MIN = 16'h0000;
	localparam logic [7:0] PSA_U8_MAX = 8'hFF;
	localparam logic [31:0] PSA_DATA_RST = 32'h0000_0000;
	localparam logic [4:0] PSA_ADDR_RST = 5'h00;
	// Write-back follows issue by one edge: zero delay slots
	localparam int PSA_RESULT_LATENCY = 1;

	typedef enum logic [1:0] {
		PSA_MODE_SIGNED_PAIR = 2'h0,
		PSA_MODE_UNSIGNED_SIGNED_PAIR = 2'h1,
		PSA_MODE_UNSIGNED_QUAD = 2'h3,
		PSA_MODE_NONE = 2'h2
	} psa_mode_type;
endpackage

// ===== rtl/psa_lane_if.sv
// Purpose: Carries one half-word lane between the core and a lane adder
// Assumes: Purely combinational lane
// Notes: Core drives operands and mode, lane returns the clamped half
`timescale 1ns/1ns
interface psa_lane_if;
	import psa_pkg::*;
	psa_mode_type mode;
	logic [15:0] opA;
	logic [15:0] opB;
	logic [15:0] sum;
	modport core (output mode, output opA, output opB, input sum);
	modport lane (input mode, input opA, input opB, output sum);
endinterface

// ===== rtl/psa_lane.sv
// Purpose: One 16-bit lane: signed pair, mixed-sign pair or two unsigned bytes
// Assumes: Mode is stable for the cycle
// Notes: No carry ever leaves the lane
`timescale 1ns/1ns
module psa_lane
	import psa_pkg::*;
(
	psa_lane_if.lane lane
);
	logic [16:0] signedSum;
	logic [17:0] mixedSum;
	logic [8:0] byteSum [2];
	logic [15:0] byteRes;

	always_comb begin
		// Sign-extend one bit so overflow shows as disagreeing top bits
		signedSum = {lane.opA[15], lane.opA} + {lane.opB[15], lane.opB};
		// Unsigned first operand, signed second: two guard bits cover both ends
		mixedSum = {2'b00, lane.opA} + {{2{lane.opB[15]}}, lane.opB};
		byteRes = 16'h0000;
		for (int i = 0; i < 2; i++) begin
			// Each byte keeps its carry to itself
			byteSum[i] = {1'b0, lane.opA[8*i +: 8]} + {1'b0, lane.opB[8*i +: 8]};
			byteRes[8*i +: 8] = byteSum[i][8] ? PSA_U8_MAX : byteSum[i][7:0];
		end
		case (lane.mode)
			PSA_MODE_SIGNED_PAIR: begin
				if (signedSum[16] != signedSum[15]) begin
					lane.sum = signedSum[16] ? PSA_S16_MIN : PSA_S16_MAX;
				end else begin
					lane.sum = signedSum[15:0];
				end
			end
			PSA_MODE_UNSIGNED_SIGNED_PAIR: begin
				if (mixedSum[17]) begin
					lane.sum = PSA_U16_MIN;
				end else if (mixedSum[16]) begin
					lane.sum = PSA_U16_MAX;
				end else begin
					lane.sum = mixedSum[15:0];
				end
			end
			PSA_MODE_UNSIGNED_QUAD: begin
				lane.sum = byteRes;
			end
			default: begin
				lane.sum = 16'h0000;
			end
		endcase
	end
endmodule

// ===== test/psa_decode_model.sv
// Purpose: Decode and register-file model that issues packed adds
// Assumes: At most one instruction per cycle
// Notes: Operands are inverted when idle so stale values never look valid
`timescale 1ns/1ns
module psa_decode_model
	import psa_pkg::*;
(
	input wire logic ref_clk,
	output logic issue,
	output logic [PSA_OPF_W-1:0] opfield,
	output logic predTrue,
	output logic [PSA_DATA_W-1:0] src1,
	output logic [PSA_DATA_W-1:0] src2,
	output logic [PSA_REG_W-1:0] dstAddr
);
	initial {issue, opfield, predTrue, src1, src2, dstAddr} = '0;
	task automatic send(input logic [3:0] op, input logic [31:0] a, input logic [31:0] b, input logic p,
		input logic [4:0] d);
		@(posedge ref_clk);
		#1;
		{issue, opfield, predTrue, src1, src2, dstAddr} = {1'b1, op, p, a, b, d};
	endtask
	// The alias has no opfield of its own: unsigned operand goes to the first source
	task automatic sendAlias(input logic [31:0] s, input logic [31:0] u, input logic [4:0] d);
		send(PSA_OPF_UNSIGNED_SIGNED_PAIR, u, s, 1'b1, d);
	endtask
	task automatic idle();
		@(posedge ref_clk);
		#1;
		{issue, src1, src2} = {1'b0, ~src1, ~src2};
	endtask
endmodule

// ===== test/tb.sv
// Purpose: Self-checking bench of the packed saturating adder
// Assumes: clkEn held high throughout
// Notes: Expected writes queue up at issue and are matched on wrEn
`timescale 1ns/1ns
module tb;
	import psa_pkg::*;
	logic ref_clk, rst_b, clkEn, issue, predTrue, wrEn, satFlagWr;
	logic [3:0] opfield;
	logic [31:0] src1, src2, wrData, r;
	logic [4:0] dstAddr, wrAddr;
	logic [36:0] expQ[$];
	logic [31:0] seed = 32'hFB23;
	logic [3:0] opTab[3] = '{4'h0, 4'h1, 4'h3};
	int num_errors = 0, cmp_count = 0;
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	psa_decode_model dm (.ref_clk(ref_clk), .issue(issue), .opfield(opfield), .predTrue(predTrue),
		.src1(src1), .src2(src2), .dstAddr(dstAddr));
	psa_packed_sat_adder uut (.ref_clk(ref_clk), .rst_b(rst_b), .clkEn(clkEn), .issue(issue),
		.opfield(opfield), .predTrue(predTrue), .src1(src1), .src2(src2), .dstAddr(dstAddr),
		.wrEn(wrEn), .wrAddr(wrAddr), .wrData(wrData), .satFlagWr(satFlagWr));
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic logic [31:0] model(input logic [3:0] op, input logic [31:0] a, input logic [31:0] b);
		logic [31:0] q;
		int s;
		q = '0;
		for (int i = 0; i < 4; i++) begin
			if (op == 4'h3) begin
				s = int'(a[8*i+:8]) + int'(b[8*i+:8]);
				q[8*i+:8] = (s > 255) ? 8'hFF : s[7:0];
			end else if (i < 2) begin
				s = (op == 4'h0 ? int'($signed(a[16*i+:16])) : int'(a[16*i+:16])) + int'($signed(b[16*i+:16]));
				if (op == 4'h0) s = s > 32767 ? 32767 : (s < -32768 ? -32768 : s);
				else s = s > 65535 ? 65535 : (s < 0 ? 0 : s);
				q[16*i+:16] = s[15:0];
			end
		end
		return q;
	endfunction
	task automatic complete_run();
		$display("compares %0d, mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic chk(input logic [36:0] got, input logic [36:0] exp);
		cmp_count++;
		if (got !== exp) begin
			num_errors++;
			$display("FAIL %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic go(input logic [3:0] op, input logic [31:0] a, input logic [31:0] b, input logic p,
		input logic [4:0] d);
		dm.send(op, a, b, p, d);
		if (p && (op == 4'h0 || op == 4'h1 || op == 4'h3)) expQ.push_back({d, model(op, a, b)});
	endtask
	// Sample mid-cycle, away from the edge that launches the outputs
	always @(negedge ref_clk) begin
		if (rst_b === 1'b1) begin
			chk({36'h0, satFlagWr}, 37'h0);
			if (wrEn !== 1'b0) begin
				if (expQ.size() == 0) chk({wrAddr, wrData}, 37'h1FFFFFFFFF);
				else chk({wrAddr, wrData}, expQ.pop_front());
			end
		end
	end
	initial begin
		#30000;
		num_errors++;
		$display("FAIL %0t: watchdog expired", $time);
		complete_run();
	end
	initial begin
		rst_b = 1'b0;
		clkEn = 1'b1;
		repeat (5) @(posedge ref_clk);
		#1 rst_b = 1'b1;
		chk({wrAddr, wrData}, 37'h0);
		go(4'h0, 32'h5789F23A, 32'h74B84975, 1'b1, 5'h09);
		go(4'h0, 32'h80008001, 32'h8001FFFE, 1'b1, 5'h1F);
		go(4'h3, 32'h5789F23A, 32'h74B84975, 1'b1, 5'h0A);
		go(4'h3, 32'h147C0124, 32'hA05101A6, 1'b1, 5'h0B);
		dm.sendAlias(32'h74B84975, 32'h5789F23A, 5'h0C);
		expQ.push_back({5'h0C, 32'hCC41FFFF});
		go(4'h1, 32'h147C0124, 32'hA05101A6, 1'b1, 5'h0D);
		go(4'h0, 32'h7FFF7FFF, 32'h7FFF7FFF, 1'b0, 5'h0E);
		go(4'h2, 32'h7FFF7FFF, 32'h7FFF7FFF, 1'b1, 5'h0F);
		$display("directed test done");
		for (int i = 0; i < 300; i++) begin
			r = xs();
			go(opTab[r % 3], xs(), xs(), r[8], r[20:16]);
		end
		dm.idle();
		repeat (3) @(posedge ref_clk);
		chk({5'h0, 32'(expQ.size())}, 37'h0);
		$display("random test done");
		complete_run();
	end
endmodule
